/* File: src/mpc_top.sv */
`include "mpc_params.svh"
`default_nettype none

module mpc_top
   import mpc_pkg::*;
#(
   parameter logic [22:0] HOLD_50  = 23'(`MPC_T50_MS * `MPC_CLK_KHZ),
   parameter logic [22:0] HOLD_100 = 23'(`MPC_T100_MS * `MPC_CLK_KHZ),
   parameter logic [22:0] HOLD_200 = 23'(`MPC_T200_MS * `MPC_CLK_KHZ),
   parameter logic [22:0] HOLD_300 = 23'(`MPC_T300_MS * `MPC_CLK_KHZ),
   parameter logic [22:0] DEB_CYC  = 23'(`MPC_DEB_MS * `MPC_CLK_KHZ)
)(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic link_scl,
   input  wire logic sda_in,
   output var  logic sda_out,
   output var  logic sda_oe,
   input  wire logic write_protect_pin,
   input  wire logic program_voltage_in,
   input  wire logic supply_ok_in,
   input  wire logic manual_reset_in,
   input  wire logic mon2_above_in,
   input  wire logic mon3_above_in,
   output var  logic supply_reset_out,
   output var  logic monitor2_out,
   output var  logic monitor3_out,
   output var  logic pot_vol_write_ok,
   output var  logic pot_nv_write_ok,
   output var  mpc_thr_s thr_prog
);

   // Hold time lookup from the two delay select bits
   function automatic logic [22:0] hold_of(input logic hi, input logic lo);
      logic [22:0] v;
      v = HOLD_100;
      case ({hi, lo})
         2'b00:   v = HOLD_50;
         2'b01:   v = HOLD_100;
         2'b10:   v = HOLD_200;
         default: v = HOLD_300;
      endcase
      return v;
   endfunction : hold_of

   // Link domain: bits shift in on each rising edge of the bus clock
   logic [7:0] link_sh_ff;
   always_ff @(posedge link_scl) begin
      link_sh_ff <= {link_sh_ff[6:0], sda_in};
   end

   // Two-stage synchronisers for every level entering the clock domain
   localparam int NS = 16;
   logic [NS-1:0] meta_ff;
   logic [NS-1:0] sync_ff;
   logic [NS-1:0] async_in;
   // Bus lines rest high, so the edge detectors see no false edge after reset
   localparam logic [NS-1:0] SYNC_IDLE = 16'h00C0;
   assign async_in = {link_sh_ff, link_scl, sda_in, write_protect_pin, program_voltage_in,
                      supply_ok_in, manual_reset_in, mon2_above_in, mon3_above_in};
   always_ff @(posedge clock) begin
      if (rst) begin
         meta_ff <= SYNC_IDLE;
         sync_ff <= SYNC_IDLE;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   logic [7:0] byte_s;
   logic       scl_s, sda_s, wp_s, vp_s, sup_s, mr_s, m2_s, m3_s;
   assign {byte_s, scl_s, sda_s, wp_s, vp_s, sup_s, mr_s, m2_s, m3_s} = sync_ff;

   // Previous levels for edge detection
   logic scl_d_ff, sda_d_ff, m2_d_ff, m3_d_ff;
   always_ff @(posedge clock) begin
      if (rst) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
         m2_d_ff  <= 1'b0;
         m3_d_ff  <= 1'b0;
      end else begin
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
         m2_d_ff  <= m2_s;
         m3_d_ff  <= m3_s;
      end
   end

   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise  = scl_s & ~scl_d_ff;
   assign scl_fall  = ~scl_s & scl_d_ff;
   assign bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
   assign bus_stop  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

   // Protocol engine state
   mpc_state_e state_ff;
   logic [3:0] bit_cnt_ff;
   logic       is_thr_ff;
   logic       is_rd_ff;
   logic       ack_ok_ff;
   logic [7:0] reg_addr_ff;
   logic [7:0] wdata_ff;
   logic [7:0] rd_word_ff;
   logic       pend_ff;
   mpc_csr_s   csr_ff;
   logic       sda_drv_ff;

   // Read image with the reserved bit forced low
   mpc_csr_s csr_rd;
   always_comb begin
      csr_rd      = csr_ff;
      csr_rd.rsv4 = 1'b0;
   end

   // Address and byte decode, the bus engine, and the acknowledge drive
   always_ff @(posedge clock) begin
      if (rst) begin
         state_ff    <= ST_IDLE;
         bit_cnt_ff  <= 4'h0;
         is_thr_ff   <= 1'b0;
         is_rd_ff    <= 1'b0;
         ack_ok_ff   <= 1'b0;
         reg_addr_ff <= 8'h00;
         wdata_ff    <= 8'h00;
         rd_word_ff  <= 8'h00;
         pend_ff     <= 1'b0;
         sda_drv_ff  <= 1'b0;
      end else if (bus_start) begin
         state_ff   <= ST_DEV;
         bit_cnt_ff <= 4'h0;
         pend_ff    <= 1'b0;
         sda_drv_ff <= 1'b0;
      end else if (bus_stop) begin
         state_ff   <= ST_IDLE;
         bit_cnt_ff <= 4'h0;
         pend_ff    <= 1'b0;
         sda_drv_ff <= 1'b0;
      end else if (scl_rise && state_ff != ST_IDLE) begin
         bit_cnt_ff <= bit_cnt_ff + 4'h1;
         // A taken byte allows only the single clock of the STOP; more aborts it
         if (pend_ff && bit_cnt_ff != 4'h0) begin
            state_ff <= ST_SKIP;
            pend_ff  <= 1'b0;
         end
      end else if (scl_fall && bit_cnt_ff == 4'h8 && state_ff != ST_RDATA) begin
         // Whole byte received: decide on acknowledge
         ack_ok_ff <= 1'b0;
         if (state_ff == ST_DEV) begin
            is_rd_ff <= 1'b0;
            if (byte_s == `MPC_DEV_WR) begin
               is_thr_ff  <= 1'b0;
               sda_drv_ff <= 1'b1;
               ack_ok_ff  <= 1'b1;
            end else if (byte_s == `MPC_DEV_THR && vp_s) begin
               is_thr_ff  <= 1'b1;
               sda_drv_ff <= 1'b1;
               ack_ok_ff  <= 1'b1;
            end else if (byte_s == `MPC_DEV_RD && reg_addr_ff == `MPC_CSR_OFF) begin
               is_rd_ff   <= 1'b1;
               sda_drv_ff <= 1'b1;
               ack_ok_ff  <= 1'b1;
               rd_word_ff <= csr_rd;
            end
         end else if (state_ff == ST_REG) begin
            reg_addr_ff <= byte_s;
            if (is_thr_ff || byte_s == `MPC_CSR_OFF) begin
               sda_drv_ff <= 1'b1;
               ack_ok_ff  <= 1'b1;
            end
         end else if (state_ff == ST_WDATA && !pend_ff && wdata_ff == 8'h00) begin
            // Only the first data byte is taken; a second aborts the write
            if (is_thr_ff || csr_ff.write_enable_latch || byte_s == 8'h02) begin
               sda_drv_ff <= 1'b1;
               ack_ok_ff  <= 1'b1;
               wdata_ff   <= byte_s;
            end
         end
      end else if (scl_fall && bit_cnt_ff == 4'h9) begin
         // Acknowledge slot over: advance or give up on the frame
         bit_cnt_ff <= 4'h0;
         sda_drv_ff <= 1'b0;
         if (state_ff == ST_RDATA) begin
            state_ff <= ST_IDLE;
         end else if (!ack_ok_ff) begin
            state_ff <= ST_SKIP;
            pend_ff  <= 1'b0;
         end else if (state_ff == ST_DEV && is_rd_ff) begin
            state_ff   <= ST_RDATA;
            sda_drv_ff <= ~rd_word_ff[7];
         end else if (state_ff == ST_DEV) begin
            state_ff <= ST_REG;
            wdata_ff <= 8'h00;
         end else if (state_ff == ST_REG) begin
            state_ff <= ST_WDATA;
            wdata_ff <= 8'h00;
         end else if (state_ff == ST_WDATA && !pend_ff) begin
            pend_ff  <= 1'b1;
            ack_ok_ff <= 1'b0;
         end else begin
            state_ff <= ST_SKIP;
            pend_ff  <= 1'b0;
         end
      end else if (scl_fall && state_ff == ST_RDATA && bit_cnt_ff < 4'h8) begin
         // Shift the read word out, most significant bit first
         sda_drv_ff <= ~rd_word_ff[3'(4'h7 - bit_cnt_ff)];
      end else if (scl_fall && state_ff == ST_RDATA) begin
         sda_drv_ff <= 1'b0;
      end
   end

   assign sda_oe = sda_drv_ff;

   // Open-drain data line only ever pulls low
   always_ff @(posedge clock) begin
      if (rst) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // Commit qualifies on STOP right after a complete, acknowledged data byte
   logic commit;
   assign commit = bus_stop && pend_ff && state_ff == ST_WDATA && bit_cnt_ff == 4'h1;

   // Control/status register updates
   always_ff @(posedge clock) begin
      if (rst) begin
         csr_ff <= `MPC_CSR_RST;
      end else begin
         // Writing 02h is how the latch gets set, so that byte alone needs no latch
         if (commit && !is_thr_ff && (csr_ff.write_enable_latch || wdata_ff == 8'h02)) begin
            if (!wp_s) begin
               csr_ff.write_enable_latch <= wdata_ff[1];
               if (!csr_ff.reg_write_enable_latch) begin
                  csr_ff.reg_write_enable_latch <= wdata_ff[2] & wdata_ff[1];
               end else if (!wdata_ff[2]) begin
                  csr_ff.reg_write_enable_latch      <= 1'b0;
                  csr_ff.sel_hi    <= wdata_ff[7];
                  csr_ff.sel_lo    <= wdata_ff[0];
                  csr_ff.pot_lock  <= wdata_ff[3];
                  csr_ff.rsv4      <= wdata_ff[4];
                  csr_ff.mon2_flag <= wdata_ff[6] & m2_s;
                  csr_ff.mon3_flag <= wdata_ff[5] & m3_s;
               end
            end
         end
         // Rising monitor output clears its flag, ahead of any software set
         if (m2_s && !m2_d_ff) begin
            csr_ff.mon2_flag <= 1'b0;
         end
         if (m3_s && !m3_d_ff) begin
            csr_ff.mon3_flag <= 1'b0;
         end
      end
   end

   // Threshold programming request, held until the protect pin drops
   always_ff @(posedge clock) begin
      if (rst) begin
         thr_prog <= '0;
      end else if (thr_prog.active) begin
         if (!wp_s) begin
            thr_prog <= '0;
         end
      end else if (commit && is_thr_ff && vp_s && wdata_ff == `MPC_THR_DATA) begin
         thr_prog.active <= 1'b1;
         if (reg_addr_ff == `MPC_THR1_UP || reg_addr_ff == `MPC_THR1_DN) begin
            thr_prog.target <= 2'h1;
            thr_prog.raise  <= reg_addr_ff == `MPC_THR1_UP;
         end else if (reg_addr_ff == `MPC_THR2_UP || reg_addr_ff == `MPC_THR2_DN) begin
            thr_prog.target <= 2'h2;
            thr_prog.raise  <= reg_addr_ff == `MPC_THR2_UP;
         end else if (reg_addr_ff == `MPC_THR3_UP || reg_addr_ff == `MPC_THR3_DN) begin
            thr_prog.target <= 2'h3;
            thr_prog.raise  <= reg_addr_ff == `MPC_THR3_UP;
         end else begin
            thr_prog.active <= 1'b0;
         end
      end
   end

   // Pot write permissions from the write enable latch, the lock bit and the protect pin
   always_ff @(posedge clock) begin
      if (rst) begin
         pot_vol_write_ok <= 1'b0;
         pot_nv_write_ok  <= 1'b0;
      end else begin
         pot_vol_write_ok <= csr_ff.write_enable_latch & ~csr_ff.pot_lock;
         pot_nv_write_ok  <= csr_ff.write_enable_latch & ~csr_ff.pot_lock & ~wp_s;
      end
   end

   // Manual reset debounce: follow the input once stable for the window
   logic        mr_db_ff;
   logic [22:0] deb_cnt_ff;
   always_ff @(posedge clock) begin
      if (rst) begin
         mr_db_ff   <= 1'b0;
         deb_cnt_ff <= 23'h000000;
      end else if (mr_s == mr_db_ff) begin
         deb_cnt_ff <= 23'h000000;
      end else if (deb_cnt_ff >= DEB_CYC - 23'h000001) begin
         mr_db_ff   <= mr_s;
         deb_cnt_ff <= 23'h000000;
      end else begin
         deb_cnt_ff <= deb_cnt_ff + 23'h000001;
      end
   end

   // Supply reset output with restartable hold counter
   logic        rst_cond;
   logic [22:0] hold_lim;
   logic [22:0] hold_cnt_ff;
   assign rst_cond = ~sup_s | mr_db_ff;
   assign hold_lim = hold_of(csr_ff.sel_hi, csr_ff.sel_lo);
   always_ff @(posedge clock) begin
      if (rst) begin
         supply_reset_out <= 1'b1;
         hold_cnt_ff      <= 23'h000000;
      end else if (rst_cond) begin
         supply_reset_out <= 1'b1;
         hold_cnt_ff      <= 23'h000000;
      end else if (supply_reset_out) begin
         if (hold_cnt_ff >= hold_lim - 23'h000001) begin
            supply_reset_out <= 1'b0;
         end else begin
            hold_cnt_ff <= hold_cnt_ff + 23'h000001;
         end
      end
   end

   // Monitor outputs follow the synchronised comparators
   always_ff @(posedge clock) begin
      if (rst) begin
         monitor2_out <= 1'b0;
         monitor3_out <= 1'b0;
      end else begin
         monitor2_out <= m2_s;
         monitor3_out <= m3_s;
      end
   end

   chk_low_supply: assert property (@(posedge clock) disable iff (rst)
      !sup_s |=> supply_reset_out)
      else $error("reset output not high with supply low");

   chk_manual_force: assert property (@(posedge clock) disable iff (rst)
      mr_db_ff |=> supply_reset_out ##0 hold_cnt_ff == 23'h000000)
      else $error("manual reset did not force output");

   chk_hold_length: assert property (@(posedge clock) disable iff (rst)
      $fell(supply_reset_out) |-> $past(hold_cnt_ff) == $past(hold_lim) - 23'h000001)
      else $error("reset released before hold time");

   chk_hold_restart: assert property (@(posedge clock) disable iff (rst)
      supply_reset_out && !rst_cond ##1 rst_cond |=> hold_cnt_ff == 23'h000000)
      else $error("hold counter not restarted");

   chk_latch_gate: assert property (@(posedge clock) disable iff (rst)
      $rose(csr_ff.reg_write_enable_latch) |-> $past(csr_ff.write_enable_latch) && !$past(wp_s))
      else $error("register latch set without write latch");

   chk_protect_nv: assert property (@(posedge clock) disable iff (rst)
      wp_s |=> $stable({csr_ff.sel_hi, csr_ff.sel_lo, csr_ff.pot_lock}))
      else $error("nonvolatile bits changed under protect");

   chk_lock_blocks: assert property (@(posedge clock) disable iff (rst)
      csr_ff.pot_lock |=> !pot_vol_write_ok && !pot_nv_write_ok)
      else $error("pot write allowed while locked");

   chk_flag_clear: assert property (@(posedge clock) disable iff (rst)
      m2_s && !m2_d_ff |=> !csr_ff.mon2_flag ##1 monitor2_out)
      else $error("monitor two flag not cleared");

   chk_one_byte: assert property (@(posedge clock) disable iff (rst)
      state_ff == ST_RDATA && scl_fall && bit_cnt_ff == 4'h9 && !bus_start && !bus_stop
      |=> state_ff == ST_IDLE)
      else $error("read did not return to idle");

   chk_rsv_zero: assert property (@(posedge clock) disable iff (rst)
      state_ff == ST_RDATA && scl_fall && bit_cnt_ff == 4'h3 |=> sda_oe)
      else $error("reserved bit read as one");

endmodule : mpc_top
`default_nettype wire

/* File: shared/mpc_params.svh */
`ifndef MPC_PARAMS_SVH
`define MPC_PARAMS_SVH

// Bus addressing
`define MPC_DEV_WR     8'hA4
`define MPC_DEV_RD     8'hA5
`define MPC_DEV_THR    8'hA0
`define MPC_CSR_OFF    8'hFF
`define MPC_THR_DATA   8'h00
// Threshold byte addresses: raise then reset
`define MPC_THR1_UP    8'h01
`define MPC_THR2_UP    8'h09
`define MPC_THR3_UP    8'h0D
`define MPC_THR1_DN    8'h03
`define MPC_THR2_DN    8'h0B
`define MPC_THR3_DN    8'h0F
// Control/status reset value: delay select 01, all else clear
`define MPC_CSR_RST    8'h01
// Timing
`define MPC_CLK_KHZ    20000
`define MPC_T50_MS     50
`define MPC_T100_MS    100
`define MPC_T200_MS    200
`define MPC_T300_MS    300
`define MPC_DEB_MS     1

`endif

/* File: shared/mpc_pkg.sv */
`default_nettype none
package mpc_pkg;

   // Control/status register layout, bit 7 down to bit 0
   typedef struct packed {
      logic sel_hi;
      logic mon2_flag;
      logic mon3_flag;
      logic rsv4;
      logic pot_lock;
      logic reg_write_enable_latch;
      logic write_enable_latch;
      logic sel_lo;
   } mpc_csr_s;

   // Threshold programming request towards the analogue cells
   typedef struct packed {
      logic       active;
      logic       raise;
      logic [1:0] target;
   } mpc_thr_s;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_DEV   = 3'b001,
      ST_REG   = 3'b010,
      ST_WDATA = 3'b011,
      ST_RDATA = 3'b100,
      ST_SKIP  = 3'b101
   } mpc_state_e;

endpackage : mpc_pkg
`default_nettype wire

/* File: verification/mpc_bus_master.sv */
`include "mpc_params.svh"
`default_nettype none
// Behavioural 2-wire bus master running on its own link clock
module mpc_bus_master (
   input  wire logic sda,
   output var  logic scl,
   output var  logic sda_m
);
   timeunit 1ns;
   timeprecision 1ps;
   logic lk;
   // Link clock of 30 ns, phase unrelated to the system clock
   initial begin
      lk = 1'b0;
      #7;
      forever #15 lk = ~lk;
   end
   // Clock idle high and data released outside frames
   initial begin
      scl   = 1'b1;
      sda_m = 1'b1;
   end
   // Change both lines just after a link edge, then hold a third of a bit
   task automatic step(input logic c, input logic d);
      @(posedge lk);
      scl   = c;
      sda_m = d;
      repeat (9) @(posedge lk);
   endtask : step
   // Data changes only while the clock is low
   task automatic bit_io(input logic d, output logic s);
      step(1'b0, sda_m);
      step(1'b0, d);
      step(1'b1, d);
      s = sda;
   endtask : bit_io
   task automatic bus_start();
      step(1'b0, sda_m);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
   endtask : bus_start
   task automatic bus_stop();
      step(1'b0, sda_m);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask : bus_stop
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask : wr_byte
   task automatic csr_write(input logic [7:0] v, output logic [2:0] a);
      bus_start();
      wr_byte(`MPC_DEV_WR, a[2]);
      wr_byte(`MPC_CSR_OFF, a[1]);
      wr_byte(v, a[0]);
      bus_stop();
   endtask : csr_write
   // Random read: address phase, repeated start, one byte, master nack
   task automatic csr_read(output logic [7:0] d, output logic a);
      logic s;
      bus_start();
      wr_byte(`MPC_DEV_WR, s);
      wr_byte(`MPC_CSR_OFF, s);
      bus_start();
      wr_byte(`MPC_DEV_RD, a);
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(1'b1, s);
      bus_stop();
   endtask : csr_read
   task automatic thr_cmd(input logic [7:0] adr, output logic [2:0] a);
      bus_start();
      wr_byte(`MPC_DEV_THR, a[2]);
      wr_byte(adr, a[1]);
      wr_byte(`MPC_THR_DATA, a[0]);
      bus_stop();
   endtask : thr_cmd
endmodule : mpc_bus_master
`default_nettype wire

/* File: verification/tb_top.sv */
`include "mpc_params.svh"
`default_nettype none
module tb_top import mpc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLD [4] = '{50, 100, 200, 300};
   localparam int LIMIT    = 60000;
   logic       clock, rst, wp, pv, sup_ok, mr, m2, m3, lk_bit, a1;
   logic       sda_oe, sda_out, scl, sda_m, sup_rst, mo2, mo3, pv_ok, nv_ok;
   mpc_thr_s   thr;
   logic [7:0] m_csr, rd;
   logic [2:0] ak;
   int         fail_count, tests_run, cyc;
   integer     seed = 32'h7d7f;
   int         thr_q[$] = '{8'h03, 8'h0B, 8'h0F, 8'h01, 8'h09, 8'h0D};
   wire        sda_line = sda_m & (sda_oe ? sda_out : 1'b1);
   mpc_top #(
      .HOLD_50  (23'(HOLD[0])),
      .HOLD_100 (23'(HOLD[1])),
      .HOLD_200 (23'(HOLD[2])),
      .HOLD_300 (23'(HOLD[3])),
      .DEB_CYC  (23'(4))
   ) dut_u (
      .clock              (clock),
      .rst                (rst),
      .link_scl           (scl),
      .sda_in             (sda_line),
      .sda_out            (sda_out),
      .sda_oe             (sda_oe),
      .write_protect_pin  (wp),
      .program_voltage_in (pv),
      .supply_ok_in       (sup_ok),
      .manual_reset_in    (mr),
      .mon2_above_in      (m2),
      .mon3_above_in      (m3),
      .supply_reset_out   (sup_rst),
      .monitor2_out       (mo2),
      .monitor3_out       (mo3),
      .pot_vol_write_ok   (pv_ok),
      .pot_nv_write_ok    (nv_ok),
      .thr_prog           (thr)
   );
   mpc_bus_master master_u (.sda(sda_line), .scl(scl), .sda_m(sda_m));
   // System clock, 50 ns
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict
   // Cut a hang short
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         fail_count++;
         print_verdict();
      end
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      tests_run++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic chk_rng(input string n, input int lo, input int hi, input int s);
      tests_run++;
      if (s < lo || s > hi) begin
         fail_count++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", n, lo, hi, s);
      end
   endtask : chk_rng
   // Register model: latches, protect pin, flag gating, reserved bit
   function automatic void mdl_write(input logic [7:0] v);
      if (wp) return;
      if (m_csr[2] && m_csr[1]) begin
         if (!v[2]) m_csr = {v[7], v[6] & m2, v[5] & m3, 1'b0, v[3], 1'b0, v[1:0]};
      end else if (v == 8'h02 || v == 8'h00) begin
         m_csr[1] = v[1];
      end else if (v == 8'h06 && m_csr[1]) begin
         m_csr[2:1] = 2'b11;
      end
   endfunction : mdl_write
   task automatic wr(input logic [7:0] v);
      logic write_enable_latch;
      write_enable_latch = (m_csr[1] | (v == 8'h02)) & ~wp;
      master_u.csr_write(v, ak);
      chk("addr ack", 8'h03, {6'h0, ak[2:1]});
      if (write_enable_latch) chk("data ack", 8'h01, {7'h0, ak[0]});
      mdl_write(v);
   endtask : wr
   task automatic rdc();
      master_u.csr_read(rd, a1);
      chk("read ack", 8'h01, {7'h0, a1});
      chk("csr", m_csr, rd);
   endtask : rdc
   task automatic pok();
      repeat (4) @(posedge clock);
      #1 chk("pot vol", {7'h0, m_csr[1] & ~m_csr[3]}, {7'h0, pv_ok});
      chk("pot nv", {7'h0, m_csr[1] & ~m_csr[3] & ~wp}, {7'h0, nv_ok});
   endtask : pok
   task automatic wait_rel(input int h);
      int n;
      n = 0;
      while (sup_rst !== 1'b0 && n < h + 40) begin
         @(posedge clock);
         #1 n++;
      end
      chk_rng("hold", h, h + 12, n);
   endtask : wait_rel
   task automatic hold_test(input int h);
      @(posedge clock);
      sup_ok <= 1'b0;
      repeat (8) @(posedge clock);
      #1 chk("supply low", 8'h01, {7'h0, sup_rst});
      @(posedge clock);
      sup_ok <= 1'b1;
      repeat (h / 2) @(posedge clock);
      sup_ok <= 1'b0;
      repeat (3) @(posedge clock);
      sup_ok <= 1'b1;
      wait_rel(h);
   endtask : hold_test
   task automatic mon_set(input logic v);
      @(posedge clock);
      m2 <= v;
      m3 <= v;
      repeat (6) @(posedge clock);
   endtask : mon_set
   // Main sequence
   initial begin
      rst = 1'b1;
      {wp, pv, mr, m2, m3, fail_count, tests_run} = '0;
      sup_ok = 1'b1;
      m_csr = `MPC_CSR_RST;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      #1 chk("reset thr", 8'h00, {4'h0, thr});
      wait_rel(HOLD[1]);
      rdc();
      rdc();
      wr(8'h02);
      rdc();
      pok();
      @(posedge clock);
      wp <= 1'b1;
      pok();
      wr(8'h06);
      rdc();
      @(posedge clock);
      wp <= 1'b0;
      for (int s = 0; s < 4; s++) begin
         lk_bit = 1'($random(seed));
         wr(8'h06);
         rdc();
         wr({s[1], 3'b001, lk_bit, 2'b01, s[0]});
         rdc();
         pok();
         hold_test(HOLD[s]);
      end
      @(posedge clock);
      mr <= 1'b1;
      repeat (20) @(posedge clock);
      #1 chk("manual reset", 8'h01, {7'h0, sup_rst});
      @(posedge clock);
      mr <= 1'b0;
      wait_rel(HOLD[3]);
      wr(8'h06);
      wr(8'hE3);
      rdc();
      mon_set(1'b1);
      #1 chk("monitors", 8'h03, {6'h0, mo2, mo3});
      wr(8'h06);
      wr(8'hE3);
      rdc();
      mon_set(1'b0);
      mon_set(1'b1);
      m_csr[6:5] = 2'b00;
      rdc();
      wr(8'h00);
      rdc();
      master_u.thr_cmd(`MPC_THR1_UP, ak);
      chk("thr no voltage", 8'h00, {1'b0, ak, thr});
      foreach (thr_q[i]) begin
         @(posedge clock);
         pv <= 1'b1;
         wp <= 1'b1;
         repeat (4) @(posedge clock);
         master_u.thr_cmd(8'(thr_q[i]), ak);
         repeat (4) @(posedge clock);
         #1 chk("thr ack", 8'h07, {5'h0, ak});
         chk("thr req", {5'h01, 1'(i >= 3), 2'(i % 3 + 1)}, {4'h0, thr});
         @(posedge clock);
         wp <= 1'b0;
         pv <= 1'b0;
         repeat (6) @(posedge clock);
         #1 chk("thr done", 8'h00, {4'h0, thr});
      end
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
